// ### verilog/ppr_pkg.sv
// Constants for the peripheral pin remap block: route codes, reset values, pin count and owner codes.
// Assumes four 16-bit ports (A..D) indexed 0..15, route selects held by the configuration logic.
// Contract
// RULE1 - Serial port A: select 0 uses A9/A10, select 1 uses B6/B7.
// RULE2 - Serial port B: select 0 puts cts,rts,tx,rx,ck on A0-4, select 1 on D3-7.
// RULE3 - Serial port C: 00 B10-12, 01 C10-12, 11 D8-10; handshake B13-14 or D11-12.
// RULE4 - Two-wire bus: select 0 uses B6/B7, select 1 uses B8/B9.
// RULE5 - Peripheral serial A: 0 uses A4-7 plus A2-3, 1 uses A15 and B3-7.
// RULE6 - Peripheral serial C: 0 uses A15 and B3-5, 1 uses A4 and C10-12.
// RULE7 - Fieldbus A: 00 on A11/A12, 10 on B8/B9, 11 on D0/D1.
// RULE8 - Fieldbus B: select 0 on B12/B13, select 1 on B5/B6.
// RULE9 - Trim sync input from A8 at 00, from D15 at 01.
// RULE10 - Low-speed crystal enabled owns C14/C15, otherwise general purpose.
// RULE11 - Standby or battery supply forces C14/C15 into analog mode.
// RULE12 - High-speed crystal enabled owns D0/D1, otherwise general purpose.
// RULE13 - All route selects reset to zero, default mapping.
package ppr_pkg;
	localparam int PPR_PINS = 16;
	localparam logic [1:0] PPR_RT_00 = 2'h0;
	localparam logic [1:0] PPR_RT_01 = 2'h1;
	localparam logic [1:0] PPR_RT_10 = 2'h2;
	localparam logic [1:0] PPR_RT_11 = 2'h3;
	localparam logic PPR_SEL_RESET = 1'h0;
	localparam logic [1:0] PPR_SEL2_RESET = 2'h0;
	// Per-pin owner codes, sequential binary enumeration of drivers
	typedef enum logic [3:0] {
		PPR_OWN_GPIO = 4'h0,
		PPR_OWN_SERA = 4'h1,
		PPR_OWN_SERB = 4'h2,
		PPR_OWN_SERC = 4'h3,
		PPR_OWN_TWI = 4'h4,
		PPR_OWN_PSA = 4'h5,
		PPR_OWN_PSC = 4'h6,
		PPR_OWN_FBA = 4'h7,
		PPR_OWN_FBB = 4'h8,
		PPR_OWN_OSC = 4'h9,
		PPR_OWN_ANA = 4'hA
	} ppr_owner_e;
endpackage : ppr_pkg

// ### verilog/ppr_cfg_if.sv
// Interface carrying registered route selects from config holder to mux.
// Assumes one clock domain; producer registers, consumer is combinational.
`timescale 1ns/100ps
interface ppr_cfg_if;
	logic serA;
	logic serB;
	logic [1:0] serC;
	logic twi;
	logic psA;
	logic psC;
	logic [1:0] fbA;
	logic fbB;
	logic [1:0] trim;
	logic lowOsc;
	logic highOsc;
	logic lowAnalog;
	modport src (output serA, serB, serC, twi, psA, psC, fbA, fbB, trim, lowOsc, highOsc, lowAnalog);
	modport dst (input serA, serB, serC, twi, psA, psC, fbA, fbB, trim, lowOsc, highOsc, lowAnalog);
endinterface : ppr_cfg_if

// ### verilog/ppr_cfg_regs.sv
// Configuration holder: registers route selects and oscillator/power levels.
// Assumes control levels come synchronous to clk.
`timescale 1ns/100ps
module ppr_cfg_regs
	import ppr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Software route selects
	input wire logic serialARouteSel,
	input wire logic serialBRouteSel,
	input wire logic [1:0] serialCRouteSel,
	input wire logic twowireRouteSel,
	input wire logic periphSerialARouteSel,
	input wire logic periphSerialCRouteSel,
	input wire logic [1:0] fieldbusARouteSel,
	input wire logic fieldbusBRouteSel,
	input wire logic [1:0] trimSyncRouteSel,
	// Oscillator and power state
	input wire logic lowSpeedCrystalOscEn,
	input wire logic highSpeedCrystalOscEn,
	input wire logic coreStandby,
	input wire logic backupOnBattery,
	// Registered config out
	ppr_cfg_if.src cfg
);
	import ppr_pkg::*;
	logic serA_ff, serB_ff, twi_ff, psA_ff, psC_ff, fbB_ff;
	logic [1:0] serC_ff, fbA_ff, trim_ff;
	logic lowOsc_ff, highOsc_ff, lowAna_ff;
	// RULE13 zero reset selects
	always_ff @(posedge clk) begin
		if (reset) begin
			serA_ff <= PPR_SEL_RESET;
			serB_ff <= PPR_SEL_RESET;
			serC_ff <= PPR_SEL2_RESET;
			twi_ff <= PPR_SEL_RESET;
			psA_ff <= PPR_SEL_RESET;
			psC_ff <= PPR_SEL_RESET;
			fbA_ff <= PPR_SEL2_RESET;
			fbB_ff <= PPR_SEL_RESET;
			trim_ff <= PPR_SEL2_RESET;
		end else begin
			serA_ff <= serialARouteSel;
			serB_ff <= serialBRouteSel;
			serC_ff <= serialCRouteSel;
			twi_ff <= twowireRouteSel;
			psA_ff <= periphSerialARouteSel;
			psC_ff <= periphSerialCRouteSel;
			fbA_ff <= fieldbusARouteSel;
			fbB_ff <= fieldbusBRouteSel;
			trim_ff <= trimSyncRouteSel;
		end
	end
	// Oscillator and power levels
	always_ff @(posedge clk) begin
		if (reset) begin
			lowOsc_ff <= 1'h0;
			highOsc_ff <= 1'h0;
			lowAna_ff <= 1'h0;
		end else begin
			lowOsc_ff <= lowSpeedCrystalOscEn;
			highOsc_ff <= highSpeedCrystalOscEn;
			lowAna_ff <= coreStandby | backupOnBattery;
		end
	end
	// Drive interface
	assign cfg.serA = serA_ff;
	assign cfg.serB = serB_ff;
	assign cfg.serC = serC_ff;
	assign cfg.twi = twi_ff;
	assign cfg.psA = psA_ff;
	assign cfg.psC = psC_ff;
	assign cfg.fbA = fbA_ff;
	assign cfg.fbB = fbB_ff;
	assign cfg.trim = trim_ff;
	assign cfg.lowOsc = lowOsc_ff;
	assign cfg.highOsc = highOsc_ff;
	assign cfg.lowAnalog = lowAna_ff;
endmodule : ppr_cfg_regs

// ### verilog/peripheral_pin_remap.sv
// Pin remap top: steers peripheral signals onto ports A..D by route selects.
// Assumes peripheral outputs and pin inputs synchronous to clk; pad outputs registered.
`timescale 1ns/100ps
module peripheral_pin_remap
	import ppr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Route selects
	input wire logic serialARouteSel,
	input wire logic serialBRouteSel,
	input wire logic [1:0] serialCRouteSel,
	input wire logic twowireRouteSel,
	input wire logic periphSerialARouteSel,
	input wire logic periphSerialCRouteSel,
	input wire logic [1:0] fieldbusARouteSel,
	input wire logic fieldbusBRouteSel,
	input wire logic [1:0] trimSyncRouteSel,
	// Oscillator and power state
	input wire logic lowSpeedCrystalOscEn,
	input wire logic highSpeedCrystalOscEn,
	input wire logic coreStandby,
	input wire logic backupOnBattery,
	// General-purpose drive per port
	input wire logic [PPR_PINS-1:0] gpioOutA,
	input wire logic [PPR_PINS-1:0] gpioOutB,
	input wire logic [PPR_PINS-1:0] gpioOutC,
	input wire logic [PPR_PINS-1:0] gpioOutD,
	input wire logic [PPR_PINS-1:0] gpioOeA,
	input wire logic [PPR_PINS-1:0] gpioOeB,
	input wire logic [PPR_PINS-1:0] gpioOeC,
	input wire logic [PPR_PINS-1:0] gpioOeD,
	// Pad inputs
	input wire logic [PPR_PINS-1:0] padInA,
	input wire logic [PPR_PINS-1:0] padInB,
	input wire logic [PPR_PINS-1:0] padInC,
	input wire logic [PPR_PINS-1:0] padInD,
	// Pad outputs
	output logic [PPR_PINS-1:0] padOutA,
	output logic [PPR_PINS-1:0] padOutB,
	output logic [PPR_PINS-1:0] padOutC,
	output logic [PPR_PINS-1:0] padOutD,
	output logic [PPR_PINS-1:0] padOeA,
	output logic [PPR_PINS-1:0] padOeB,
	output logic [PPR_PINS-1:0] padOeC,
	output logic [PPR_PINS-1:0] padOeD,
	output logic [PPR_PINS-1:0] padAnalogC,
	output logic [PPR_PINS-1:0] padAnalogD,
	// Serial port A
	input wire logic serialATx,
	output logic serialARx,
	// Serial port B
	input wire logic serialBRts,
	input wire logic serialBTx,
	input wire logic serialBCk,
	output logic serialBCts,
	output logic serialBRx,
	// Serial port C
	input wire logic serialCRts,
	input wire logic serialCTx,
	input wire logic serialCCk,
	output logic serialCCts,
	output logic serialCRx,
	// Two-wire bus, open drain: drive low when oe
	input wire logic twowireSclOe,
	input wire logic twowireSdaOe,
	output logic twowireSclIn,
	output logic twowireSdaIn,
	// Peripheral serial A (master or slave by oe)
	input wire logic [5:0] periphSerialAOut,
	input wire logic [5:0] periphSerialAOe,
	output logic [5:0] periphSerialAIn,
	// Peripheral serial C / audio (sel, ck, miso, mosi)
	input wire logic [3:0] periphSerialCOut,
	input wire logic [3:0] periphSerialCOe,
	output logic [3:0] periphSerialCIn,
	// Fieldbus ports
	input wire logic fieldbusATx,
	output logic fieldbusARx,
	input wire logic fieldbusBTx,
	output logic fieldbusBRx,
	// Trim sync and oscillator ownership
	output logic trimSyncInput,
	output logic lowOscPinsOwned,
	output logic highOscPinsOwned
);
	import ppr_pkg::*;
	ppr_cfg_if cfg ();
	logic [PPR_PINS-1:0] nxt_outA, nxt_outB, nxt_outC, nxt_outD;
	logic [PPR_PINS-1:0] nxt_oeA, nxt_oeB, nxt_oeC, nxt_oeD;
	logic [PPR_PINS-1:0] nxt_anaC, nxt_anaD;
	logic [PPR_PINS-1:0] outA_ff, outB_ff, outC_ff, outD_ff;
	logic [PPR_PINS-1:0] oeA_ff, oeB_ff, oeC_ff, oeD_ff, anaC_ff, anaD_ff;
	logic serCHand;

	// Registered selects
	ppr_cfg_regs u_cfg (
		.clk(clk),
		.reset(reset),
		.serialARouteSel(serialARouteSel),
		.serialBRouteSel(serialBRouteSel),
		.serialCRouteSel(serialCRouteSel),
		.twowireRouteSel(twowireRouteSel),
		.periphSerialARouteSel(periphSerialARouteSel),
		.periphSerialCRouteSel(periphSerialCRouteSel),
		.fieldbusARouteSel(fieldbusARouteSel),
		.fieldbusBRouteSel(fieldbusBRouteSel),
		.trimSyncRouteSel(trimSyncRouteSel),
		.lowSpeedCrystalOscEn(lowSpeedCrystalOscEn),
		.highSpeedCrystalOscEn(highSpeedCrystalOscEn),
		.coreStandby(coreStandby),
		.backupOnBattery(backupOnBattery),
		.cfg(cfg.src)
	);

	// Handshake pins of serial C follow full remap only
	assign serCHand = (cfg.serC == PPR_RT_11);

	// Output steering: GPIO first, later peripheral overlays win
	always_comb begin
		nxt_outA = gpioOutA;
		nxt_outB = gpioOutB;
		nxt_outC = gpioOutC;
		nxt_outD = gpioOutD;
		nxt_oeA = gpioOeA;
		nxt_oeB = gpioOeB;
		nxt_oeC = gpioOeC;
		nxt_oeD = gpioOeD;
		nxt_anaC = '0;
		nxt_anaD = '0;
		// RULE1 serial A tx
		if (cfg.serA) begin
			nxt_outB[6] = serialATx;
			nxt_oeB[6] = 1'h1;
			nxt_oeB[7] = 1'h0;
		end else begin
			nxt_outA[9] = serialATx;
			nxt_oeA[9] = 1'h1;
			nxt_oeA[10] = 1'h0;
		end
		// RULE2 serial B pins
		if (cfg.serB) begin
			nxt_oeD[3] = 1'h0;
			nxt_outD[4] = serialBRts;
			nxt_oeD[4] = 1'h1;
			nxt_outD[5] = serialBTx;
			nxt_oeD[5] = 1'h1;
			nxt_oeD[6] = 1'h0;
			nxt_outD[7] = serialBCk;
			nxt_oeD[7] = 1'h1;
		end else begin
			nxt_oeA[0] = 1'h0;
			nxt_outA[1] = serialBRts;
			nxt_oeA[1] = 1'h1;
			nxt_outA[2] = serialBTx;
			nxt_oeA[2] = 1'h1;
			nxt_oeA[3] = 1'h0;
			nxt_outA[4] = serialBCk;
			nxt_oeA[4] = 1'h1;
		end
		// RULE3 serial C data pins
		case (cfg.serC)
			PPR_RT_01: begin
				nxt_outC[10] = serialCTx;
				nxt_oeC[10] = 1'h1;
				nxt_oeC[11] = 1'h0;
				nxt_outC[12] = serialCCk;
				nxt_oeC[12] = 1'h1;
			end
			PPR_RT_11: begin
				nxt_outD[8] = serialCTx;
				nxt_oeD[8] = 1'h1;
				nxt_oeD[9] = 1'h0;
				nxt_outD[10] = serialCCk;
				nxt_oeD[10] = 1'h1;
			end
			default: begin
				nxt_outB[10] = serialCTx;
				nxt_oeB[10] = 1'h1;
				nxt_oeB[11] = 1'h0;
				nxt_outB[12] = serialCCk;
				nxt_oeB[12] = 1'h1;
			end
		endcase
		// RULE3 serial C handshake
		if (serCHand) begin
			nxt_oeD[11] = 1'h0;
			nxt_outD[12] = serialCRts;
			nxt_oeD[12] = 1'h1;
		end else begin
			nxt_oeB[13] = 1'h0;
			nxt_outB[14] = serialCRts;
			nxt_oeB[14] = 1'h1;
		end
		// RULE4 two-wire open drain
		if (cfg.twi) begin
			nxt_outB[8] = 1'h0;
			nxt_oeB[8] = twowireSclOe;
			nxt_outB[9] = 1'h0;
			nxt_oeB[9] = twowireSdaOe;
		end else begin
			nxt_outB[6] = 1'h0;
			nxt_oeB[6] = twowireSclOe;
			nxt_outB[7] = 1'h0;
			nxt_oeB[7] = twowireSdaOe;
		end
		// RULE5 peripheral serial A
		if (cfg.psA) begin
			nxt_outA[15] = periphSerialAOut[0];
			nxt_oeA[15] = periphSerialAOe[0];
			for (int i = 1; i < 6; i++) begin
				nxt_outB[i+2] = periphSerialAOut[i];
				nxt_oeB[i+2] = periphSerialAOe[i];
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				nxt_outA[i+4] = periphSerialAOut[i];
				nxt_oeA[i+4] = periphSerialAOe[i];
			end
			nxt_outA[2] = periphSerialAOut[4];
			nxt_oeA[2] = periphSerialAOe[4];
			nxt_outA[3] = periphSerialAOut[5];
			nxt_oeA[3] = periphSerialAOe[5];
		end
		// RULE6 peripheral serial C
		if (cfg.psC) begin
			nxt_outA[4] = periphSerialCOut[0];
			nxt_oeA[4] = periphSerialCOe[0];
			for (int i = 1; i < 4; i++) begin
				nxt_outC[i+9] = periphSerialCOut[i];
				nxt_oeC[i+9] = periphSerialCOe[i];
			end
		end else begin
			nxt_outA[15] = periphSerialCOut[0];
			nxt_oeA[15] = periphSerialCOe[0];
			for (int i = 1; i < 4; i++) begin
				nxt_outB[i+2] = periphSerialCOut[i];
				nxt_oeB[i+2] = periphSerialCOe[i];
			end
		end
		// RULE7 fieldbus A
		case (cfg.fbA)
			PPR_RT_10: begin
				nxt_oeB[8] = 1'h0;
				nxt_outB[9] = fieldbusATx;
				nxt_oeB[9] = 1'h1;
			end
			PPR_RT_11: begin
				nxt_oeD[0] = 1'h0;
				nxt_outD[1] = fieldbusATx;
				nxt_oeD[1] = 1'h1;
			end
			default: begin
				nxt_oeA[11] = 1'h0;
				nxt_outA[12] = fieldbusATx;
				nxt_oeA[12] = 1'h1;
			end
		endcase
		// RULE8 fieldbus B
		if (cfg.fbB) begin
			nxt_oeB[5] = 1'h0;
			nxt_outB[6] = fieldbusBTx;
			nxt_oeB[6] = 1'h1;
		end else begin
			nxt_oeB[12] = 1'h0;
			nxt_outB[13] = fieldbusBTx;
			nxt_oeB[13] = 1'h1;
		end
		// RULE12 high crystal owns D0/D1
		if (cfg.highOsc) begin
			nxt_outD[1:0] = 2'h0;
			nxt_oeD[1:0] = 2'h0;
			nxt_anaD[1:0] = 2'h3;
		end
		// RULE10 low crystal owns C14/C15
		if (cfg.lowOsc) begin
			nxt_outC[15:14] = 2'h0;
			nxt_oeC[15:14] = 2'h0;
			nxt_anaC[15:14] = 2'h3;
		end
		// RULE11 power loss forces analog
		if (cfg.lowAnalog) begin
			nxt_outC[15:14] = 2'h0;
			nxt_oeC[15:14] = 2'h0;
			nxt_anaC[15:14] = 2'h3;
		end
	end

	// Pad output registers
	always_ff @(posedge clk) begin
		if (reset) begin
			outA_ff <= '0;
			outB_ff <= '0;
			outC_ff <= '0;
			outD_ff <= '0;
			oeA_ff <= '0;
			oeB_ff <= '0;
			oeC_ff <= '0;
			oeD_ff <= '0;
			anaC_ff <= '0;
			anaD_ff <= '0;
		end else begin
			outA_ff <= nxt_outA;
			outB_ff <= nxt_outB;
			outC_ff <= nxt_outC;
			outD_ff <= nxt_outD;
			oeA_ff <= nxt_oeA;
			oeB_ff <= nxt_oeB;
			oeC_ff <= nxt_oeC;
			oeD_ff <= nxt_oeD;
			anaC_ff <= nxt_anaC;
			anaD_ff <= nxt_anaD;
		end
	end
	assign padOutA = outA_ff;
	assign padOutB = outB_ff;
	assign padOutC = outC_ff;
	assign padOutD = outD_ff;
	assign padOeA = oeA_ff;
	assign padOeB = oeB_ff;
	assign padOeC = oeC_ff;
	assign padOeD = oeD_ff;
	assign padAnalogC = anaC_ff;
	assign padAnalogD = anaD_ff;

	// Input steering, combinational from pads and selects
	always_comb begin
		// RULE1 serial A rx
		serialARx = cfg.serA ? padInB[7] : padInA[10];
		// RULE2 serial B inputs
		serialBCts = cfg.serB ? padInD[3] : padInA[0];
		serialBRx = cfg.serB ? padInD[6] : padInA[3];
		// RULE3 serial C inputs
		case (cfg.serC)
			PPR_RT_01: serialCRx = padInC[11];
			PPR_RT_11: serialCRx = padInD[9];
			default: serialCRx = padInB[11];
		endcase
		serialCCts = serCHand ? padInD[11] : padInB[13];
		// RULE4 two-wire inputs
		twowireSclIn = cfg.twi ? padInB[8] : padInB[6];
		twowireSdaIn = cfg.twi ? padInB[9] : padInB[7];
		// RULE5 peripheral serial A inputs
		if (cfg.psA) begin
			periphSerialAIn = {padInB[7:3], padInA[15]};
		end else begin
			periphSerialAIn = {padInA[3:2], padInA[7:4]};
		end
		// RULE6 peripheral serial C inputs
		if (cfg.psC) begin
			periphSerialCIn = {padInC[12:10], padInA[4]};
		end else begin
			periphSerialCIn = {padInB[5:3], padInA[15]};
		end
		// RULE7 fieldbus A rx
		case (cfg.fbA)
			PPR_RT_10: fieldbusARx = padInB[8];
			PPR_RT_11: fieldbusARx = padInD[0];
			default: fieldbusARx = padInA[11];
		endcase
		// RULE8 fieldbus B rx
		fieldbusBRx = cfg.fbB ? padInB[5] : padInB[12];
		// RULE9 trim sync source
		case (cfg.trim)
			PPR_RT_01: trimSyncInput = padInD[15];
			default: trimSyncInput = padInA[8];
		endcase
		lowOscPinsOwned = cfg.lowOsc;
		highOscPinsOwned = cfg.highOsc;
	end
endmodule : peripheral_pin_remap

// ### tb/ppr_assertions.sv
// Checker for the pin remap block: input steering, default pads and oscillator pin ownership.
// Assumes selects take one edge to register and pads one edge more.
`timescale 1ns/100ps
module ppr_assertions
	import ppr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Route selects and oscillator state
	input wire logic serialARouteSel,
	input wire logic serialBRouteSel,
	input wire logic [1:0] serialCRouteSel,
	input wire logic twowireRouteSel,
	input wire logic [1:0] fieldbusARouteSel,
	input wire logic [1:0] trimSyncRouteSel,
	input wire logic lowSpeedCrystalOscEn,
	input wire logic highSpeedCrystalOscEn,
	input wire logic coreStandby,
	input wire logic backupOnBattery,
	// Pads
	input wire logic [PPR_PINS-1:0] padInA,
	input wire logic [PPR_PINS-1:0] padInB,
	input wire logic [PPR_PINS-1:0] padInC,
	input wire logic [PPR_PINS-1:0] padInD,
	input wire logic [PPR_PINS-1:0] padOutA,
	input wire logic [PPR_PINS-1:0] padOeA,
	input wire logic [PPR_PINS-1:0] padAnalogC,
	input wire logic [PPR_PINS-1:0] padAnalogD,
	// Peripheral side
	input wire logic serialATx,
	input wire logic serialARx,
	input wire logic serialBRx,
	input wire logic serialCRx,
	input wire logic twowireSdaIn,
	input wire logic fieldbusARx,
	input wire logic trimSyncInput
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_ser_a_rx;
		serialARx == ((!$past(reset) && $past(serialARouteSel)) ? padInB[7] : padInA[10]);
	endproperty
	a_ser_a_rx: assert property (p_ser_a_rx) else $error("serial a receive pin wrong");
	sequence s_sera_dflt;
		!serialARouteSel ##1 1'b1;
	endsequence
	property p_ser_a_tx;
		s_sera_dflt |=> padOeA[9] && padOutA[9] == $past(serialATx);
	endproperty
	a_ser_a_tx: assert property (p_ser_a_tx) else $error("serial a transmit pad wrong");
	property p_ser_b_rx;
		serialBRx == ((!$past(reset) && $past(serialBRouteSel)) ? padInD[6] : padInA[3]);
	endproperty
	a_ser_b_rx: assert property (p_ser_b_rx) else $error("serial b receive pin wrong");
	property p_ser_c_rx;
		serialCRx == ($past(reset) ? padInB[11] : $past(serialCRouteSel) == 2'h1 ? padInC[11] :
			$past(serialCRouteSel) == 2'h3 ? padInD[9] : padInB[11]);
	endproperty
	a_ser_c_rx: assert property (p_ser_c_rx) else $error("serial c receive pin wrong");
	property p_twi_sda;
		twowireSdaIn == ((!$past(reset) && $past(twowireRouteSel)) ? padInB[9] : padInB[7]);
	endproperty
	a_twi_sda: assert property (p_twi_sda) else $error("two-wire data pin wrong");
	property p_fba_rx;
		fieldbusARx == ($past(reset) ? padInA[11] : $past(fieldbusARouteSel) == 2'h2 ? padInB[8] :
			$past(fieldbusARouteSel) == 2'h3 ? padInD[0] : padInA[11]);
	endproperty
	a_fba_rx: assert property (p_fba_rx) else $error("fieldbus a receive pin wrong");
	property p_trim;
		trimSyncInput == ((!$past(reset) && $past(trimSyncRouteSel) == 2'h1) ? padInD[15] : padInA[8]);
	endproperty
	a_trim: assert property (p_trim) else $error("trim sync pin wrong");
	property p_low_osc;
		padAnalogC[15:14] == {2{!$past(reset) && !$past(reset, 2) && ($past(lowSpeedCrystalOscEn, 2) ||
			$past(coreStandby, 2) || $past(backupOnBattery, 2))}};
	endproperty
	a_low_osc: assert property (p_low_osc) else $error("low oscillator pins wrong");
	property p_high_osc;
		padAnalogD[1:0] == {2{!$past(reset) && !$past(reset, 2) && $past(highSpeedCrystalOscEn, 2)}};
	endproperty
	a_high_osc: assert property (p_high_osc) else $error("high oscillator pins wrong");
endmodule : ppr_assertions

bind peripheral_pin_remap ppr_assertions chk_u (.*);

// ### tb/ppr_pins.sv
// Far-side pin model: a changing level on every pad the block leaves undriven.
// Assumes push-pull pads; a driven pad reads back the block's own level.
`timescale 1ns/100ps
module ppr_pins
	import ppr_pkg::*;
(
	// Clock
	input wire logic clk,
	// Pad drive from the block
	input wire logic [PPR_PINS-1:0] padOutA,
	input wire logic [PPR_PINS-1:0] padOutB,
	input wire logic [PPR_PINS-1:0] padOutC,
	input wire logic [PPR_PINS-1:0] padOutD,
	input wire logic [PPR_PINS-1:0] padOeA,
	input wire logic [PPR_PINS-1:0] padOeB,
	input wire logic [PPR_PINS-1:0] padOeC,
	input wire logic [PPR_PINS-1:0] padOeD,
	// Resolved pad levels
	output logic [PPR_PINS-1:0] padInA,
	output logic [PPR_PINS-1:0] padInB,
	output logic [PPR_PINS-1:0] padInC,
	output logic [PPR_PINS-1:0] padInD
);
	logic [63:0] pat_ff = 64'h0123456789ABCDEF;

	// Shifts one place each cycle, top bit fed back inverted, so far-side levels keep changing
	always @(posedge clk) begin
		pat_ff <= #1 {pat_ff[62:0], ~pat_ff[63]};
	end

	// Block drive where enabled, far side elsewhere
	assign padInA = (padOeA & padOutA) | (~padOeA & pat_ff[15:0]);
	assign padInB = (padOeB & padOutB) | (~padOeB & pat_ff[31:16]);
	assign padInC = (padOeC & padOutC) | (~padOeC & pat_ff[47:32]);
	assign padInD = (padOeD & padOutD) | (~padOeD & pat_ff[63:48]);
endmodule : ppr_pins

// ### tb/peripheral_pin_remap_bench.sv
// Bench for the pin remap block: hand-written scenarios over routes and oscillator pins.
// Assumes the pin model resolves every pad and the checker is bound to the block.
`timescale 1ns/100ps
module peripheral_pin_remap_bench;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic serialARouteSel, serialBRouteSel, twowireRouteSel, periphSerialARouteSel, periphSerialCRouteSel;
	logic fieldbusBRouteSel, lowSpeedCrystalOscEn, highSpeedCrystalOscEn, coreStandby, backupOnBattery;
	logic [1:0] serialCRouteSel, fieldbusARouteSel, trimSyncRouteSel;
	logic [15:0] gpioOutA, gpioOutB, gpioOutC, gpioOutD, gpioOeA, gpioOeB, gpioOeC, gpioOeD;
	logic [15:0] padInA, padInB, padInC, padInD, padOutA, padOutB, padOutC, padOutD;
	logic [15:0] padOeA, padOeB, padOeC, padOeD, padAnalogC, padAnalogD;
	logic serialATx, serialBRts, serialBTx, serialBCk, serialCRts, serialCTx, serialCCk;
	logic twowireSclOe, twowireSdaOe, fieldbusATx, fieldbusBTx, serialARx, serialBCts, serialBRx;
	logic serialCCts, serialCRx, twowireSclIn, twowireSdaIn, fieldbusARx, fieldbusBRx;
	logic trimSyncInput, lowOscPinsOwned, highOscPinsOwned;
	logic [5:0] periphSerialAOut, periphSerialAOe, periphSerialAIn;
	logic [3:0] periphSerialCOut, periphSerialCOe, periphSerialCIn;
	int num_errors = 0;
	int comparisons = 0;
	wire [63:0] pIn = {padInD, padInC, padInB, padInA};
	wire [63:0] pOut = {padOutD, padOutC, padOutB, padOutA};
	wire [63:0] pOe = {padOeD, padOeC, padOeB, padOeA};

	// Clock
	always #2 clk = ~clk;

	peripheral_pin_remap dut_u (.*);
	ppr_pins pins_u (.*);

	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	task automatic settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic chk(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %0t pin level got %b want %b", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	// defaults hold until the first edge
	task automatic t_reset;
		@(negedge clk);
		chk(serialARx, pIn[10]);
		chk(serialCRx, pIn[27]);
		chk(fieldbusARx, pIn[11]);
		chk(fieldbusBRx, pIn[28]);
		@(negedge clk);
		chk(serialARx, pIn[23]);
		chk(serialCRx, pIn[57]);
		step();
		{serialARouteSel, serialBRouteSel, twowireRouteSel, periphSerialARouteSel, periphSerialCRouteSel,
			fieldbusBRouteSel, serialCRouteSel, fieldbusARouteSel, trimSyncRouteSel} = '0;
	endtask : t_reset

	task automatic t_serial_ab;
		for (int s = 0; s < 2; s++) begin
			step();
			{serialARouteSel, serialBRouteSel, twowireRouteSel} = {s[0], s[0], 1'h1};
			{serialATx, serialBRts} = {!s[0], s[0]};
			settle();
			chk(serialARx, pIn[s ? 23 : 10]);
			chk(pOut[s ? 22 : 9], !s[0]);
			chk(pOe[s ? 22 : 9], 1'h1);
			chk(serialBRx, pIn[s ? 54 : 3]);
			chk(serialBCts, pIn[s ? 51 : 0]);
			chk(pOut[s ? 52 : 1], s[0]);
		end
	endtask : t_serial_ab

	task automatic t_serial_c;
		int tx;
		for (int c = 0; c < 4; c++) begin
			step();
			{serialCRouteSel, serialCTx, serialCRts} = {c[1:0], c[0], !c[0]};
			settle();
			tx = c == 1 ? 42 : c == 3 ? 56 : 26;
			chk(serialCRx, pIn[tx + 1]);
			chk(pOut[tx], c[0]);
			chk(serialCCts, pIn[c == 3 ? 59 : 29]);
			chk(pOut[c == 3 ? 60 : 30], !c[0]);
		end
	endtask : t_serial_c

	task automatic t_bus;
		int r;
		for (int c = 0; c < 4; c++) begin
			step();
			{twowireRouteSel, fieldbusBRouteSel, twowireSclOe} = {c[0], c[0], 1'h1};
			{fieldbusARouteSel, trimSyncRouteSel, fieldbusATx, fieldbusBTx} = {c[1:0], c[1:0], c[0], !c[0]};
			settle();
			r = c == 2 ? 24 : c == 3 ? 48 : 11;
			chk(fieldbusARx, pIn[r]);
			chk(pOut[r + 1], c[0]);
			chk(trimSyncInput, pIn[c == 1 ? 63 : 8]);
			chk(fieldbusBRx, pIn[c[0] ? 21 : 28]);
			chk(pOut[c[0] ? 22 : 29], !c[0]);
			chk(twowireSdaIn, pIn[c[0] ? 25 : 23]);
			chk(twowireSclIn, pIn[c[0] ? 24 : 22]);
			if (c < 2) chk(pOe[c[0] ? 24 : 22] & !pOut[c[0] ? 24 : 22], 1'h1);
		end
	endtask : t_bus

	task automatic t_periph;
		int pa [2][6] = '{'{4, 5, 6, 7, 2, 3}, '{15, 19, 20, 21, 22, 23}};
		int pc [2][4] = '{'{15, 19, 20, 21}, '{4, 42, 43, 44}};
		for (int s = 0; s < 2; s++) begin
			step();
			{periphSerialARouteSel, periphSerialCRouteSel, serialCRouteSel, fieldbusBRouteSel} = {s[0], s[0], 3'h0};
			{periphSerialAOut, periphSerialAOe, periphSerialCOut, periphSerialCOe} = {6'h2D, 6'h15, 4'h9, 4'h5};
			settle();
			for (int i = 0; i < 6; i++) chk(pOut[pa[s][i]], periphSerialAOut[i]);
			for (int i = 0; i < 6; i++) chk(periphSerialAIn[i], pIn[pa[s][i]]);
			for (int i = 0; i < 4; i++) chk(pOut[pc[s][i]], periphSerialCOut[i]);
			for (int i = 0; i < 4; i++) chk(periphSerialCIn[i], pIn[pc[s][i]]);
		end
	endtask : t_periph

	task automatic t_osc;
		logic lo;
		step();
		{gpioOutC, gpioOeC, gpioOutD, gpioOeD, fieldbusARouteSel} = {16'hC000, 16'hFFFF, 16'h0003, 16'hFFFF, 2'h0};
		for (int c = 0; c < 5; c++) begin
			step();
			{lowSpeedCrystalOscEn, highSpeedCrystalOscEn, coreStandby, backupOnBattery} = c ? 4'h8 >> (c - 1) : 4'h0;
			settle();
			lo = c == 1 || c > 2;
			chk(padAnalogC[14], lo);
			chk(padAnalogC[15], lo);
			chk(pOe[46] & pOut[47], !lo);
			chk(lowOscPinsOwned, c == 1);
			chk(padAnalogD[1], c == 2);
			chk(pOe[48] & pOut[49], c != 2);
			chk(highOscPinsOwned, c == 2);
		end
	endtask : t_osc

	// Main sequence
	initial begin
		{serialARouteSel, serialBRouteSel, twowireRouteSel, periphSerialARouteSel, periphSerialCRouteSel,
			fieldbusBRouteSel, serialCRouteSel, fieldbusARouteSel, trimSyncRouteSel} = '1;
		{lowSpeedCrystalOscEn, highSpeedCrystalOscEn, coreStandby, backupOnBattery, gpioOutA, gpioOutB,
			gpioOutC, gpioOutD, gpioOeA, gpioOeB, gpioOeC, gpioOeD} = '0;
		{serialATx, serialBRts, serialBTx, serialBCk, serialCRts, serialCTx, serialCCk, twowireSclOe,
			twowireSdaOe, fieldbusATx, fieldbusBTx, periphSerialAOut, periphSerialAOe, periphSerialCOut,
			periphSerialCOe} = '0;
		repeat (20) step();
		reset = 1'h0;
		t_reset();
		t_serial_ab();
		t_serial_c();
		t_bus();
		t_periph();
		t_osc();
		close_out();
	end

	// Watchdog well past the expected hundred or so cycles
	initial begin
		#40000;
		num_errors++;
		close_out();
	end
endmodule : peripheral_pin_remap_bench
